// [core/nv_pot_io_ctrl.sv]
`timescale 1ns/1ps
`include "nv_pot_io_map.svh"

module nv_pot_io_ctrl
  import nv_pot_io_pkg::*;
#(
  parameter int unsigned NV_WRITE_CYCLES = `NV_WRITE_MS * `REF_CLK_KHZ
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst,
  input  wire logic                          ce,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe_n,
  input  wire logic                          slave_addr_sel_0,
  input  wire logic                          slave_addr_sel_1,
  input  wire logic                          slave_addr_sel_2,
  input  wire logic [`NUM_PINS-1:0]          gp_pin_in,
  output logic      [`NUM_PINS-1:0]          gp_pin_out,
  output logic      [`NUM_PINS-1:0]          gp_pin_oe_n,
  output logic      [`NUM_PINS-1:0]          pin_pullup_resistor,
  output logic      [`NUM_WIPERS-1:0][7:0]   wiper_terminals,
  output logic                               nv_busy
);

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  pin_sample_t raw_s;
  pin_sample_t syn_s;
  logic        scl_d_r;
  logic        sda_d_r;

  assign raw_s = '{gp_in: gp_pin_in,
                   addr_sel: {slave_addr_sel_2, slave_addr_sel_1, slave_addr_sel_0},
                   sda: sda_in, scl: scl_in};

  sync2 #(.WIDTH(`SYNC_WIDTH)) u_sync (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .d       (raw_s),
    .q       (syn_s)
  );

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce) begin
      scl_d_r <= syn_s.scl;
      sda_d_r <= syn_s.sda;
    end
  end

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  assign start_det = syn_s.scl & scl_d_r & sda_d_r & ~syn_s.sda;
  assign stop_det  = syn_s.scl & scl_d_r & ~sda_d_r & syn_s.sda;
  assign scl_rise  = syn_s.scl & ~scl_d_r;
  assign scl_fall  = ~syn_s.scl & scl_d_r;

  // ----------------------------------------
  // register storage
  // ----------------------------------------
  logic [`NUM_WIPERS-1:0][7:0] wiper_r;
  pin_ctrl_t                   ctrl_r;
  logic [3:0]                  pin_state_r;
  logic [7:0]                  ptr_r;
  logic [7:0]                  shift_r;
  logic                        wr_en;

  function automatic logic is_wiper(input logic [7:0] a);
    return (a >= `WIPER_BASE) && (a <= `WIPER_LAST);
  endfunction : is_wiper

  function automatic logic [2:0] wiper_idx(input logic [7:0] a);
    logic [7:0] off;
    off = a - `WIPER_BASE;
    return off[2:0];
  endfunction : wiper_idx

  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    rd_byte = `UNMAPPED_READ;
    if (is_wiper(a)) begin
      rd_byte = wiper_r[wiper_idx(a)];
    end else if (a == `PIN_CTRL_ADDR) begin
      rd_byte = ctrl_r;
    end else if (a == `PIN_STAT_ADDR) begin
      rd_byte = {`STAT_RSVD, pin_state_r};
    end
  endfunction : rd_byte

  // volatile image is written at once; the nv copy follows after stop
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wiper_r <= {`NUM_WIPERS{`WIPER_RESET}};
      ctrl_r  <= `PIN_CTRL_RESET;
    end else if (ce && wr_en) begin
      if (is_wiper(ptr_r)) begin
        wiper_r[wiper_idx(ptr_r)] <= shift_r;
      end else if (ptr_r == `PIN_CTRL_ADDR) begin
        ctrl_r <= shift_r;
      end
    end
  end

  assign wiper_terminals = wiper_r;

  // ----------------------------------------
  // general-purpose pins
  // ----------------------------------------
  for (genvar i = 0; i < `NUM_PINS; i++) begin : g_pin
    logic floating;
    assign floating = ctrl_r.pullup_dis[i] & ctrl_r.setting[i];
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        gp_pin_out[i]          <= 1'b0;
        gp_pin_oe_n[i]         <= 1'b1;
        pin_pullup_resistor[i] <= 1'b0;
        pin_state_r[i]         <= 1'b0;
      end else if (ce) begin
        gp_pin_out[i]          <= ctrl_r.setting[i];
        gp_pin_oe_n[i]         <= floating;
        pin_pullup_resistor[i] <= ~ctrl_r.pullup_dis[i];
        pin_state_r[i]         <= floating ? syn_s.gp_in[i]
                                           : ctrl_r.setting[i];
      end
    end
  end

  // ----------------------------------------
  // two-wire slave
  // ----------------------------------------
  bus_state_t state_r;
  logic [3:0] bit_cnt_r;
  logic       ack_phase_r;
  logic [7:0] tx_r;
  logic       wrote_r;
  logic       addr_hit;
  logic [7:0] rd_now;

  assign addr_hit = (shift_r[7:1] == {`DEV_TYPE, syn_s.addr_sel})
                    && !nv_busy;
  assign wr_en    = scl_fall && !ack_phase_r && (bit_cnt_r == `BIT_LAST)
                    && (state_r == st_wdata);
  // always_comb also wakes on the registers that the function reads
  always_comb begin
    rd_now = rd_byte(ptr_r);
  end
  assign sda_out  = 1'b0;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_r     <= st_idle;
      bit_cnt_r   <= '0;
      ack_phase_r <= 1'b0;
      shift_r     <= '0;
      tx_r        <= '0;
      ptr_r       <= '0;
      wrote_r     <= 1'b0;
      sda_oe_n    <= 1'b1;
    end else if (ce) begin
      if (stop_det) begin
        state_r  <= st_idle;
        wrote_r  <= 1'b0;
        sda_oe_n <= 1'b1;
      end else if (start_det) begin
        state_r     <= st_addr;
        bit_cnt_r   <= '0;
        ack_phase_r <= 1'b0;
        sda_oe_n    <= 1'b1;
      end else if (state_r != st_idle && scl_rise) begin
        if (!ack_phase_r) begin
          shift_r   <= {shift_r[6:0], syn_s.sda};
          bit_cnt_r <= bit_cnt_r + 4'h1;
        end else if (state_r == st_rdata && syn_s.sda) begin
          state_r <= st_idle;  // master nack ends the read
        end
      end else if (state_r != st_idle && scl_fall) begin
        if (ack_phase_r) begin
          ack_phase_r <= 1'b0;
          bit_cnt_r   <= '0;
          if (state_r == st_rdata) begin
            tx_r     <= {rd_now[6:0], 1'b0};
            sda_oe_n <= rd_now[7];
            ptr_r    <= ptr_r + 8'h01;
          end else begin
            sda_oe_n <= 1'b1;
          end
        end else if (bit_cnt_r == `BIT_LAST) begin
          ack_phase_r <= 1'b1;
          sda_oe_n    <= 1'b0;
          unique case (state_r)
            st_addr: begin
              if (addr_hit) begin
                state_r <= shift_r[0] ? st_rdata : st_word;
              end else begin
                state_r  <= st_idle;
                sda_oe_n <= 1'b1;
              end
            end
            st_word: begin
              ptr_r   <= shift_r;
              state_r <= st_wdata;
            end
            st_wdata: begin
              ptr_r   <= ptr_r + 8'h01;
              wrote_r <= 1'b1;
            end
            st_rdata: begin
              sda_oe_n <= 1'b1;  // master answers this one
            end
            st_idle: begin
              sda_oe_n <= 1'b1;
            end
          endcase
        end else if (state_r == st_rdata) begin
          sda_oe_n <= tx_r[7];
          tx_r     <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // ----------------------------------------
  // nonvolatile write timer
  // ----------------------------------------
  logic [31:0] busy_cnt_r;

  // worst-case time is always spent; no early finish to track
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      nv_busy    <= 1'b0;
      busy_cnt_r <= '0;
    end else if (ce) begin
      if (stop_det && wrote_r) begin
        nv_busy    <= 1'b1;
        busy_cnt_r <= NV_WRITE_CYCLES - 32'h1;
      end else if (nv_busy) begin
        if (busy_cnt_r == '0) begin
          nv_busy <= 1'b0;
        end else begin
          busy_cnt_r <= busy_cnt_r - 32'h1;
        end
      end
    end
  end

endmodule : nv_pot_io_ctrl

// [core/sync2.sv]
`timescale 1ns/1ps

module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end

endmodule : sync2

// [shared/nv_pot_io_map.svh]
`ifndef NV_POT_IO_MAP_SVH
`define NV_POT_IO_MAP_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define WIPER_BASE      8'hf0
`define WIPER_LAST      8'hf5
`define PIN_CTRL_ADDR   8'hf6
`define PIN_STAT_ADDR   8'hf7
`define WIPER_RESET     8'hff
`define PIN_CTRL_RESET  8'h0f
`define UNMAPPED_READ   8'hff
`define STAT_RSVD       4'h0

// ----------------------------------------
// sizes and bus framing
// ----------------------------------------
`define NUM_WIPERS      6
`define NUM_PINS        4
`define BIT_LAST        4'h8
`define SYNC_WIDTH      9
// arbitrary device type code, not tied to any product
`define DEV_TYPE        4'ha

// ----------------------------------------
// timing
// ----------------------------------------
`define NV_WRITE_MS     20
`define REF_CLK_KHZ     125000

`endif

// [shared/nv_pot_io_pkg.sv]
package nv_pot_io_pkg;

  typedef struct packed {
    logic [3:0] pullup_dis;
    logic [3:0] setting;
  } pin_ctrl_t;

  typedef struct packed {
    logic [3:0] gp_in;
    logic [2:0] addr_sel;
    logic       sda;
    logic       scl;
  } pin_sample_t;

  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_word,
    st_wdata,
    st_rdata
  } bus_state_t;

endpackage : nv_pot_io_pkg

// [sim/i2c_master_model.sv]
`timescale 1ns/1ps

module i2c_master_model (
  input  wire logic ref_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  // ----
  // bit level, 8 cycles per step: clock high for 8 and low for 16 per bit
  // ----
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : hold
  task automatic bit_io(input logic b, output logic r);
    sda_low <= !b;
    hold(8);
    scl <= 1'b1;
    hold(8);
    r = sda;
    scl <= 1'b0;
    hold(8);
  endtask : bit_io
  // also serves as repeated start
  task automatic start_c();
    sda_low <= 1'b0;
    hold(8);
    scl <= 1'b1;
    hold(8);
    sda_low <= 1'b1;
    hold(8);
    scl <= 1'b0;
    hold(8);
  endtask : start_c
  task automatic stop_c();
    sda_low <= 1'b1;
    hold(8);
    scl <= 1'b1;
    hold(8);
    sda_low <= 1'b0;
    hold(8);
  endtask : stop_c
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : put
  task automatic get(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(!more, r);
  endtask : get
endmodule : i2c_master_model

// [sim/nv_pot_and_io_control_bench.sv]
`timescale 1ns/1ps
`include "nv_pot_io_map.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end

module nv_pot_and_io_control_bench;
  localparam int unsigned NVC = 300;
  logic                        ref_clk = 1'b0;
  logic                        rst = 1'b1;
  logic [2:0]                  sel = 3'b101;
  logic [3:0]                  ext = 4'h0;
  int                          failures = 0;
  int                          total_checks = 0;
  wire                         scl;
  wire                         m_low;
  logic                        sda_oe_n, sda_out, nv_busy, k;
  logic [3:0]                  gp_out, gp_oe_n, pull;
  logic [`NUM_WIPERS-1:0][7:0] wip;
  logic [7:0]                  d;
  wire                         sda = !m_low && (sda_oe_n || sda_out);
  wire  [3:0]                  gp_in = (gp_out & ~gp_oe_n) | (ext & gp_oe_n);
  // {pointer, written, read back}
  logic [7:0] rows [9][3] = '{'{8'hf0, 8'h00, 8'h00}, '{8'hf1, 8'h5a, 8'h5a},
    '{8'hf2, 8'ha5, 8'ha5}, '{8'hf3, 8'h80, 8'h80}, '{8'hf4, 8'h01, 8'h01},
    '{8'hf5, 8'h7f, 8'h7f}, '{8'h40, 8'h12, 8'hff}, '{8'hf7, 8'h55, 8'h0f},
    '{8'hf6, 8'hf5, 8'hf5}};
  always #4 ref_clk = !ref_clk;
  nv_pot_io_ctrl #(.NV_WRITE_CYCLES(NVC)) DUT (
    .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .slave_addr_sel_0(sel[0]), .slave_addr_sel_1(sel[1]),
    .slave_addr_sel_2(sel[2]), .gp_pin_in(gp_in), .gp_pin_out(gp_out), .gp_pin_oe_n(gp_oe_n),
    .pin_pullup_resistor(pull), .wiper_terminals(wip), .nv_busy(nv_busy));
  i2c_master_model mst (.ref_clk(ref_clk), .sda(sda), .scl(scl), .sda_low(m_low));
  // ----
  // transfers
  // ----
  task automatic wait_idle();
    for (int n = 0; n < NVC + 50 && nv_busy !== 1'b0; n++) @(posedge ref_clk);
    `CHK(nv_busy, 1'b0)
  endtask : wait_idle
  task automatic addr_only(input logic [2:0] s, output logic ack);
    mst.start_c();
    mst.put({4'ha, s, 1'b0}, ack);
    mst.stop_c();
  endtask : addr_only
  task automatic xfer_wr(input logic [7:0] a, input logic [7:0] v, input logic idle);
    logic k1, k2, k3;
    mst.start_c();
    mst.put({4'ha, sel, 1'b0}, k1);
    mst.put(a, k2);
    mst.put(v, k3);
    mst.stop_c();
    `CHK({k1, k2, k3}, 3'b111)
    if (idle) wait_idle();
  endtask : xfer_wr
  task automatic xfer_rd(input logic [7:0] a, output logic [7:0] v);
    logic k1, k2, k3;
    mst.start_c();
    mst.put({4'ha, sel, 1'b0}, k1);
    mst.put(a, k2);
    mst.start_c();
    mst.put({4'ha, sel, 1'b1}, k3);
    mst.get(1'b0, v);
    mst.stop_c();
    `CHK({k1, k2, k3}, 3'b111)
  endtask : xfer_rd
  task automatic complete_run();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  // ----
  // sequence
  // ----
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    repeat (8) @(posedge ref_clk);
    `CHK(wip, {6{8'hff}})
    `CHK({gp_out, gp_oe_n, pull}, 12'hf0f)
    xfer_rd(8'hf6, d);
    `CHK(d, 8'h0f)
    addr_only(sel ^ 3'b001, k);
    `CHK(k, 1'b0)
    sel <= 3'b010;
    for (int i = 0; i < 9; i++) begin
      xfer_wr(rows[i][0], rows[i][1], 1'b1);
      xfer_rd(rows[i][0], d);
      `CHK(d, rows[i][2])
      if (i < 6) `CHK(wip[i], rows[i][2])
    end
    `CHK({gp_out, gp_oe_n, pull}, 12'h550)
    xfer_rd(8'hf7, d);
    `CHK(d, 8'h00)
    ext <= 4'h5;
    xfer_rd(8'hf7, d);
    `CHK(d, 8'h05)
    xfer_wr(8'hf0, 8'h33, 1'b0);
    `CHK(nv_busy, 1'b1)
    addr_only(sel, k);
    `CHK(k, 1'b0)
    wait_idle();
    addr_only(sel, k);
    `CHK(k, 1'b1)
    rst <= 1'b1;
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK(wip, {6{8'hff}})
    // pin outputs leave their reset image one edge after release
    @(posedge ref_clk);
    `CHK({gp_out, gp_oe_n, pull}, 12'hf0f)
    complete_run();
  end
  initial begin
    repeat (80000) @(posedge ref_clk);
    failures++;
    complete_run();
  end
endmodule : nv_pot_and_io_control_bench

// [sim/nv_pot_io_checker.sv]
`timescale 1ns/1ps
`include "nv_pot_io_map.svh"

module nv_pot_io_checker #(
  parameter int unsigned NV_WRITE_CYCLES = 50
) (
  input wire logic                        ref_clk,
  input wire logic                        rst,
  input wire logic                        scl_in,
  input wire logic                        sda_in,
  input wire logic                        sda_oe_n,
  input wire logic [`NUM_PINS-1:0]        gp_pin_out,
  input wire logic [`NUM_PINS-1:0]        gp_pin_oe_n,
  input wire logic [`NUM_PINS-1:0]        pin_pullup_resistor,
  input wire logic [`NUM_WIPERS-1:0][7:0] wiper_terminals,
  input wire logic                        nv_busy
);
  // ----
  // helper counters
  // ----
  int unsigned busy_cnt;
  int unsigned since_stop;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) busy_cnt <= 0;
    else busy_cnt <= nv_busy ? busy_cnt + 1 : 0;
  end
  // raw pins, so the design's sync delay must fit in the slack
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) since_stop <= 255;
    else if (scl_in && sda_in && !$past(sda_in)) since_stop <= 0;
    else if (since_stop < 255) since_stop <= since_stop + 1;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // reset values are all hi-z, so the first edge after release is skipped
  a_pin_truth: assert property (!$past(rst) |->
    gp_pin_oe_n == (~pin_pullup_resistor & gp_pin_out))
    else $error("pin enable does not match control");
  a_busy_after_stop: assert property ($rose(nv_busy) |-> since_stop <= 8)
    else $error("write timer began without a stop");
  a_busy_length: assert property ($fell(nv_busy) |->
    busy_cnt >= NV_WRITE_CYCLES - 1 && busy_cnt <= NV_WRITE_CYCLES + 1)
    else $error("write timer length wrong");
  a_no_ack_busy: assert property (nv_busy |-> !$fell(sda_oe_n))
    else $error("sda pulled while busy");
  a_ack_held: assert property ($rose(scl_in) && !sda_oe_n |=> !sda_oe_n [*3])
    else $error("sda released during clock high");
  a_sda_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda changed while clock high");
  a_wiper_update: assert property ($changed(wiper_terminals) |-> !scl_in && !nv_busy)
    else $error("wiper changed outside a write");
  // pins leave their reset image one edge after release, with the bus idle
  a_pins_update: assert property (!$past(rst, 2) && $changed(gp_pin_out) |-> !scl_in)
    else $error("pin setting changed outside a write");
  c_busy: cover property ($rose(nv_busy));
  c_ack: cover property ($fell(sda_oe_n));
  c_float: cover property (gp_pin_oe_n != 4'h0);
endmodule : nv_pot_io_checker

bind nv_pot_io_ctrl nv_pot_io_checker #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) chk (
  .ref_clk(ref_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .gp_pin_out(gp_pin_out), .gp_pin_oe_n(gp_pin_oe_n), .pin_pullup_resistor(pin_pullup_resistor),
  .wiper_terminals(wiper_terminals), .nv_busy(nv_busy));
